/* hdl/can_fault_pkg.sv */
// Package with constants and types for the transceiver fault monitor
package can_fault_pkg;
  // AXI4-Lite register byte offsets
  localparam logic [7:0] STATUS_OFFS = 8'h00;
  localparam logic [7:0] CTRL_OFFS = 8'h04;
  localparam logic [7:0] MASK_OFFS = 8'h08;
  // Status register bit positions
  localparam int THERMAL_FAULT_FLAG_BIT = 0;
  localparam int CUR_BIT = 1;
  localparam int TOUT_BIT = 2;
  localparam int WAKE_BIT = 3;
  localparam int STATUS_W = 4;
  // Control register fields
  localparam int SLEW_LSB = 0;
  localparam int NORMAL_BIT = 2;
  // Reset values
  localparam logic [1:0] SLEW_RST = 2'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int TOUT_US = 350;
  localparam int TOUT_MIN_US = 200;
  localparam int TOUT_MAX_US = 520;
  localparam int TOUT_CYC = TOUT_US * CLK_MHZ;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic thermal;
    logic overcurH;
    logic overcurL;
    logic wake;
  } fault_in_t;

  typedef struct packed {
    logic drvEnable;
    logic busDominant;
    logic [1:0] slewRate;
  } drive_out_t;

  typedef enum logic [1:0] {DRV_IDLE, DRV_DOM, DRV_FAULT} drv_state_t;
endpackage : can_fault_pkg

/* hdl/can_transceiver_fault_monitor.sv */
// Fault supervision of a CAN transceiver with AXI4-Lite status access
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module can_transceiver_fault_monitor
  import can_fault_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TOUT_CYC
)(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic txIn,
  input wire logic busRx,
  input wire fault_in_t faultIn,
  output drive_out_t driveOut,
  output logic rxOut,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == STATUS_OFFS) || (a == CTRL_OFFS) || (a == MASK_OFFS);
  endfunction : known_addr

  // Driver supervision
  drv_state_t drvState_ff, nxt_drvState;
  logic [31:0] domCnt_ff, nxt_domCnt;
  logic timeoutEvt;
  drive_out_t driveOut_ff, nxt_driveOut;
  logic rxOut_ff;

  // Registers
  logic [STATUS_W-1:0] status_ff, nxt_status;
  logic [STATUS_W-1:0] mask_ff, nxt_mask;
  logic [1:0] slew_ff, nxt_slew;
  logic normal_ff, nxt_normal;
  logic irq_ff, nxt_irq;

  // AXI state
  logic awHave_ff, nxt_awHave, wHave_ff, nxt_wHave;
  logic [7:0] awAddr_ff, nxt_awAddr;
  logic [31:0] wData_ff, nxt_wData;
  logic [3:0] wStrb_ff, nxt_wStrb;
  logic bValid_ff, nxt_bValid;
  logic [1:0] bResp_ff, nxt_bResp;
  logic rValid_ff, nxt_rValid;
  logic [31:0] rData_ff, nxt_rData;
  logic [1:0] rResp_ff, nxt_rResp;
  logic statusRead, doWrite;

  always_comb
  begin
    nxt_drvState = drvState_ff;
    nxt_domCnt = domCnt_ff;
    timeoutEvt = 1'b0;
    unique case (drvState_ff)
      DRV_IDLE:
      begin
        nxt_domCnt = 32'h0;
        if (!txIn)
          nxt_drvState = DRV_DOM;
      end
      DRV_DOM:
      begin
        if (txIn)
          nxt_drvState = DRV_IDLE;
        else if (domCnt_ff >= 32'(TIMEOUT_CYCLES - 2))
        begin
          nxt_drvState = DRV_FAULT;
          timeoutEvt = 1'b1;
        end
        else
          nxt_domCnt = domCnt_ff + 32'h1;
      end
      DRV_FAULT:
      begin
        // Stays off while transmit is stuck low
        if (txIn)
          nxt_drvState = DRV_IDLE;
      end
    endcase
    nxt_driveOut.drvEnable = (nxt_drvState != DRV_FAULT);
    nxt_driveOut.busDominant = !txIn && (nxt_drvState != DRV_FAULT);
    nxt_driveOut.slewRate = slew_ff;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drvState_ff <= DRV_IDLE;
      domCnt_ff <= 32'h0;
      driveOut_ff <= '0;
      rxOut_ff <= 1'b1;
    end
    else
    begin
      drvState_ff <= nxt_drvState;
      domCnt_ff <= nxt_domCnt;
      driveOut_ff <= nxt_driveOut;
      rxOut_ff <= busRx;
    end
  end

  // AXI4-Lite slave; single outstanding write and read
  always_comb
  begin
    nxt_awHave = awHave_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wHave = wHave_ff;
    nxt_wData = wData_ff;
    nxt_wStrb = wStrb_ff;
    nxt_bValid = bValid_ff;
    nxt_bResp = bResp_ff;
    nxt_rValid = rValid_ff;
    nxt_rData = rData_ff;
    nxt_rResp = rResp_ff;
    statusRead = 1'b0;
    if (s_axi_awvalid && !awHave_ff)
    begin
      nxt_awHave = 1'b1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHave_ff)
    begin
      nxt_wHave = 1'b1;
      nxt_wData = s_axi_wdata;
      nxt_wStrb = s_axi_wstrb;
    end
    doWrite = awHave_ff && wHave_ff && !bValid_ff;
    if (doWrite)
    begin
      nxt_awHave = 1'b0;
      nxt_wHave = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp = known_addr(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bValid_ff && s_axi_bready)
      nxt_bValid = 1'b0;
    if (s_axi_arvalid && !rValid_ff)
    begin
      nxt_rValid = 1'b1;
      nxt_rResp = RESP_OKAY;
      nxt_rData = 32'h0;
      unique case (s_axi_araddr)
        STATUS_OFFS:
        begin
          nxt_rData[STATUS_W-1:0] = status_ff;
          statusRead = 1'b1;
        end
        CTRL_OFFS:
        begin
          nxt_rData[SLEW_LSB +: 2] = slew_ff;
          nxt_rData[NORMAL_BIT] = normal_ff;
        end
        MASK_OFFS:
          nxt_rData[STATUS_W-1:0] = mask_ff;
        default:
          nxt_rResp = RESP_SLVERR;
      endcase
    end
    if (rValid_ff && s_axi_rready)
      nxt_rValid = 1'b0;
  end

  // Register file, status flags and interrupt
  always_comb
  begin
    nxt_slew = slew_ff;
    nxt_normal = normal_ff;
    nxt_mask = mask_ff;
    nxt_status = status_ff;
    if (doWrite && wStrb_ff[0])
    begin
      if (awAddr_ff == CTRL_OFFS)
      begin
        nxt_slew = wData_ff[SLEW_LSB +: 2];
        nxt_normal = wData_ff[NORMAL_BIT];
      end
      if (awAddr_ff == MASK_OFFS)
        nxt_mask = wData_ff[STATUS_W-1:0];
    end
    // Read clears error flags; wake clears only via normal mode
    if (statusRead)
    begin
      nxt_status[THERMAL_FAULT_FLAG_BIT] = 1'b0;
      nxt_status[CUR_BIT] = 1'b0;
      nxt_status[TOUT_BIT] = 1'b0;
    end
    if (nxt_normal)
      nxt_status[WAKE_BIT] = 1'b0;
    // Set wins over read clear so no error event is lost; wake sets only outside normal mode
    if (faultIn.thermal)
      nxt_status[THERMAL_FAULT_FLAG_BIT] = 1'b1;
    if (faultIn.overcurH || faultIn.overcurL)
      nxt_status[CUR_BIT] = 1'b1;
    if (timeoutEvt)
      nxt_status[TOUT_BIT] = 1'b1;
    if (faultIn.wake && !nxt_normal)
      nxt_status[WAKE_BIT] = 1'b1;
    nxt_irq = |(nxt_status & nxt_mask);
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awHave_ff <= 1'b0;
      awAddr_ff <= 8'h0;
      wHave_ff <= 1'b0;
      wData_ff <= 32'h0;
      wStrb_ff <= 4'h0;
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
      rValid_ff <= 1'b0;
      rData_ff <= 32'h0;
      rResp_ff <= RESP_OKAY;
      slew_ff <= SLEW_RST;
      normal_ff <= 1'b0;
      mask_ff <= MASK_RST;
      status_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      awHave_ff <= nxt_awHave;
      awAddr_ff <= nxt_awAddr;
      wHave_ff <= nxt_wHave;
      wData_ff <= nxt_wData;
      wStrb_ff <= nxt_wStrb;
      bValid_ff <= nxt_bValid;
      bResp_ff <= nxt_bResp;
      rValid_ff <= nxt_rValid;
      rData_ff <= nxt_rData;
      rResp_ff <= nxt_rResp;
      slew_ff <= nxt_slew;
      normal_ff <= nxt_normal;
      mask_ff <= nxt_mask;
      status_ff <= nxt_status;
      irq_ff <= nxt_irq;
    end
  end

  assign driveOut = driveOut_ff;
  assign rxOut = rxOut_ff;
  assign irq = irq_ff;
  assign s_axi_awready = !awHave_ff;
  assign s_axi_wready = !wHave_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_arready = !rValid_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;

  // Checks
  default clocking chkClk @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // Timeout cycle excluded: it hands over to the fault state
  chk_dom_drive: assert property (
    (!txIn && drvState_ff == DRV_DOM && !timeoutEvt) |=> driveOut.busDominant)
    else $error("dominant not driven");
  chk_rec_drive: assert property (
    txIn |=> !driveOut.busDominant)
    else $error("recessive not kept");
  chk_tout_fault: assert property (
    timeoutEvt |=> !driveOut.drvEnable && status_ff[TOUT_BIT])
    else $error("timeout not acted on");
  chk_fault_off: assert property (
    (drvState_ff == DRV_FAULT && !txIn) |=> !driveOut.busDominant)
    else $error("bus driven in fault");
  chk_fault_exit: assert property (
    (drvState_ff == DRV_FAULT) && txIn |=> drvState_ff == DRV_IDLE)
    else $error("no recovery on recessive");
  chk_thermal_fault_flag_set: assert property (
    faultIn.thermal |=> status_ff[THERMAL_FAULT_FLAG_BIT])
    else $error("thermal flag missing");
  chk_cur_set: assert property (
    (faultIn.overcurH || faultIn.overcurL) |=> status_ff[CUR_BIT])
    else $error("overcurrent flag missing");
  chk_flag_hold: assert property (
    (status_ff[THERMAL_FAULT_FLAG_BIT] && !statusRead) |=> status_ff[THERMAL_FAULT_FLAG_BIT])
    else $error("thermal flag lost");
  chk_wake_clr: assert property (
    normal_ff |-> !status_ff[WAKE_BIT])
    else $error("wake flag set in normal");
  chk_slew_out: assert property (
    ##1 driveOut.slewRate == $past(slew_ff))
    else $error("slew not applied");
  cov_timeout: cover property (@(posedge sys_clk) disable iff (!arst_n)
    timeoutEvt);
  cov_recover: cover property (@(posedge sys_clk) disable iff (!arst_n)
    drvState_ff == DRV_FAULT ##1 drvState_ff == DRV_IDLE);
  cov_irq: cover property (@(posedge sys_clk) disable iff (!arst_n) irq);
endmodule : can_transceiver_fault_monitor

/* verif/can_ctrl_model.sv */
// Controller model that drives the transmit input and samples receive
`timescale 1ns/1ns
module can_ctrl_model
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic domReq,
  input wire logic rxOut,
  output logic txIn,
  output logic rxSeen
);
  logic txIn_ff;
  logic rxSeen_ff;
  assign txIn = txIn_ff;
  assign rxSeen = rxSeen_ff;
  // Dropping domReq is the only way out of a timeout
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txIn_ff <= 1'h1;
      rxSeen_ff <= 1'h1;
    end
    else
    begin
      txIn_ff <= ~domReq;
      rxSeen_ff <= rxOut;
    end
  end
endmodule : can_ctrl_model

/* verif/can_transceiver_fault_monitor_tb.sv */
// Self-checking bench for the transceiver fault monitor
`timescale 1ns/1ns
module can_transceiver_fault_monitor_tb import can_fault_pkg::*;;
  // Short timeout keeps the run brief
  localparam int TCYC = 20;
  logic sys_clk = 1'h0;
  logic arst_n = 1'h0;
  logic domReq = 1'h0;
  logic txIn, rxOut, irq, rxSeen, busRx;
  fault_in_t faultIn = '0;
  drive_out_t driveOut;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fail_count = 0;
  int checks = 0;
  // Bus loopback: receiver sees what the driver puts on the bus
  assign busRx = ~driveOut.busDominant;
  can_transceiver_fault_monitor #(.TIMEOUT_CYCLES(TCYC)) u_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .txIn(txIn), .busRx(busRx),
    .faultIn(faultIn), .driveOut(driveOut), .rxOut(rxOut), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  can_ctrl_model u_ctrl (.sys_clk(sys_clk), .arst_n(arst_n),
    .domReq(domReq), .rxOut(rxOut), .txIn(txIn), .rxSeen(rxSeen));
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic end_of_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic hang;
    fail_count++;
    $display("BAD t=%0t bus wait ran out", $time);
    end_of_test();
  endtask : hang
  task automatic at(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : at
  // Ready sampled at the negedge equals its value at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic ta, tw, tb;
    tb = 1'h0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 40 && !tb; n++)
    begin
      @(negedge sys_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      if (tb) cmp(32'(s_axi_bresp), 32'(er));
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) s_axi_bready <= 1'h0;
    end
    if (!tb) hang();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    logic ta, tr;
    tr = 1'h0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 40 && !tr; n++)
    begin
      @(negedge sys_clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      if (tr) cmp(s_axi_rdata, ed);
      if (tr) cmp(32'(s_axi_rresp), 32'(er));
      @(posedge sys_clk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) s_axi_rready <= 1'h0;
    end
    if (!tr) hang();
  endtask : rd
  // Field order: thermal, overcurH, overcurL, wake
  task automatic pulse(input logic [3:0] f);
    @(posedge sys_clk);
    faultIn <= f;
    @(posedge sys_clk);
    faultIn <= '0;
  endtask : pulse
  initial
  begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'h1;
    rd(STATUS_OFFS, 32'h0, RESP_OKAY);
    rd(CTRL_OFFS, 32'(SLEW_RST), RESP_OKAY);
    rd(MASK_OFFS, 32'(MASK_RST), RESP_OKAY);
    wr(8'h0c, 32'h1, RESP_SLVERR);
    rd(8'h0c, 32'h0, RESP_SLVERR);
    $display("test reset and map done");
    for (int i = 0; i < 4; i++)
    begin
      wr(CTRL_OFFS, 32'(i), RESP_OKAY);
      // Output flop loads one edge after the register
      at(1);
      cmp(32'(driveOut.slewRate), 32'(i));
      rd(CTRL_OFFS, 32'(i), RESP_OKAY);
    end
    $display("test slew done");
    @(posedge sys_clk);
    domReq <= 1'h1;
    at(TCYC - 5);
    cmp(32'(driveOut.busDominant), 32'h1);
    cmp(32'(driveOut.drvEnable), 32'h1);
    cmp(32'(rxSeen), 32'h0);
    @(posedge sys_clk);
    domReq <= 1'h0;
    at(3);
    cmp(32'(driveOut.busDominant), 32'h0);
    rd(STATUS_OFFS, 32'h0, RESP_OKAY);
    @(posedge sys_clk);
    domReq <= 1'h1;
    at(TCYC + 6);
    cmp(32'(driveOut.drvEnable), 32'h0);
    cmp(32'(driveOut.busDominant), 32'h0);
    at(8);
    cmp(32'(driveOut.drvEnable), 32'h0);
    @(posedge sys_clk);
    domReq <= 1'h0;
    at(3);
    cmp(32'(driveOut.drvEnable), 32'h1);
    rd(STATUS_OFFS, 32'h4, RESP_OKAY);
    rd(STATUS_OFFS, 32'h0, RESP_OKAY);
    $display("test dominant timeout done");
    pulse(4'h8);
    at(2);
    cmp(32'(irq), 32'h0);
    wr(MASK_OFFS, 32'h1, RESP_OKAY);
    at(2);
    cmp(32'(irq), 32'h1);
    rd(STATUS_OFFS, 32'h1, RESP_OKAY);
    at(2);
    cmp(32'(irq), 32'h0);
    pulse(4'h4);
    rd(STATUS_OFFS, 32'h2, RESP_OKAY);
    pulse(4'h2);
    rd(STATUS_OFFS, 32'h2, RESP_OKAY);
    $display("test fault flags done");
    pulse(4'h1);
    rd(STATUS_OFFS, 32'h8, RESP_OKAY);
    rd(STATUS_OFFS, 32'h8, RESP_OKAY);
    wr(CTRL_OFFS, 32'h4, RESP_OKAY);
    rd(STATUS_OFFS, 32'h0, RESP_OKAY);
    $display("test wake done");
    end_of_test();
  end
endmodule : can_transceiver_fault_monitor_tb
